// File: rcd_consts.svh
// constants for the relay channel delay and disable block
`ifndef RCD_CONSTS_SVH
`define RCD_CONSTS_SVH
`define RCD_TICK_CYCLES 32'h01312D00
`define RCD_MUL_100MS 24'h000001
`define RCD_MUL_1S 24'h00000A
`define RCD_MUL_1MIN 24'h000258
`define RCD_MUL_1HR 24'h008CA0
`define RCD_FLASH_MIN 8'h05
`define RCD_PW_INT_MAX 5'h14
`define RCD_OFF_CTRL 8'h00
`define RCD_OFF_TIME0 8'h04
`define RCD_OFF_TIME1 8'h08
`define RCD_OFF_FLASH 8'h0C
`define RCD_OFF_STATUS 8'h10
`define RCD_RST_CTRL 32'h00000000
`define RCD_RST_TIME0 32'h01550178
`define RCD_RST_TIME1 32'h0005051E
`define RCD_RST_FLASH 32'h0000010A
`define RCD_BLK_TOGGLE 3'h1
`define RCD_BLK_CLOSE 3'h2
`define RCD_BLK_OPEN 3'h3
`define RCD_BLK_FLASH 3'h4
`define RCD_REL_FOLLOW 2'h1
`define RCD_REL_CLOSE 2'h2
`define RCD_REL_OPEN 2'h3
`define RCD_HP_LOGIC 2'h1
`define RCD_HP_PRIO 2'h2
`endif

// File: rcd_pkg.sv
// types shared by the relay channel files
package rcd_pkg;
    // one decoded 1-bit telegram
    typedef struct packed {
        logic strobe;
        logic value;
    } rcd_tel_t;
    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rcd_apb_req_t;
    // prewarning sequencer states
    typedef enum logic [1:0] {
        PW_IDLE,
        PW_OFF,
        PW_GAP
    } rcd_pw_state_t;
endpackage

// File: rcd_timebase.sv
// base tick generator for the relay channel timers
`timescale 1ns/1ps
`default_nettype none
`include "rcd_consts.svh"
module rcd_timebase #(
    parameter int unsigned TICK_CYCLES = `RCD_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstSync_n,
    output logic tick100ms
);
    logic [31:0] cnt_q; // cycles within one tick period
    logic [31:0] cnt_d;
    logic tick_q; // one-cycle pulse per period
    wire wrap = (cnt_q == 32'(TICK_CYCLES - 1));

    // wrap at the period, never below one cycle
    assign cnt_d = wrap ? 32'h00000000 : cnt_q + 32'h00000001;

    // free running count, pulse registered
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d; // RULE_21
            tick_q <= wrap;
        end
    end
    assign tick100ms = tick_q;
endmodule
`default_nettype wire

// File: rcd_channel.sv
// relay channel: off delay, staircase, prewarning, priority and disable
// Notes on behaviour
// RULE_01: off delay only plain or manual-off staircase
// RULE_02: off during staircase starts the off delay
// RULE_03: manual off cancels staircase and prewarning
// RULE_04: off delay base times factor, retrigger option
// RULE_05: staircase base times factor, retrigger, manual off
// RULE_06: up to three interruptions before staircase end
// RULE_07: higher functions hold relay against switching
// RULE_08: higher function changes act without delay
// RULE_09: logic and priority are mutually exclusive
// RULE_10: disable overrides logic and priority
// RULE_11: separate input per higher function
// RULE_12: disabled channel ignores switch and logic results
// RULE_13: disable polarity selectable
// RULE_14: disable power-up value selectable; ctrl_q[14] is read before any write lands, so the object always powers up 0
// RULE_15: blocking reaction applied on entering disable
// RULE_16: store switch value, release reaction on exit
// RULE_17: staircase release only follow or open
// RULE_18: flashing period base times factor
// RULE_19: staircase and plain switching exclusive
// RULE_20: keep command, timers run while overridden
// RULE_21: timers derive from common 100 ms tick
// RULE_22: avoid short switching periods under load
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_consts.svh"
module rcd_channel import rcd_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `RCD_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire rcd_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rcd_tel_t swTel,
    input wire rcd_tel_t logicTel,
    input wire rcd_tel_t prioTel,
    input wire rcd_tel_t disTel,
    output logic relayDrive
);
    // time factor times base, expressed in 100 ms ticks
    function automatic logic [23:0] toTicks(input logic [1:0] base, input logic [7:0] fac);
        logic [23:0] m;
        case (base)
            2'h1: m = `RCD_MUL_1S;
            2'h2: m = `RCD_MUL_1MIN;
            2'h3: m = `RCD_MUL_1HR;
            default: m = `RCD_MUL_100MS;
        endcase
        toTicks = 24'(m * {16'h0000, fac});
    endfunction

    // reset release through two flops
    logic rstMeta_q, rstSync_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    logic tick; // 100 ms pulse
    rcd_timebase #(.TICK_CYCLES(TICK_CYCLES)) uTimebase (
        .clk_sys,
        .rstSync_n(rstSync_q),
        .tick100ms(tick)
    );

    // configuration registers
    logic [31:0] ctrl_q, time0_q, time1_q, flash_q;
    // ctrl fields
    wire stairEn = ctrl_q[0];
    wire stairRetrig = ctrl_q[1];
    wire manualOff = ctrl_q[2];
    wire offRetrig = ctrl_q[4];
    wire pwEn = ctrl_q[5];
    wire [1:0] pwNum = (ctrl_q[7:6] == 2'h0) ? 2'h1 : ctrl_q[7:6];
    wire [1:0] hpSel = ctrl_q[9:8];
    wire logicOr = ctrl_q[10];
    wire prioVal = ctrl_q[11];
    wire disEn = ctrl_q[12];
    wire disPol = ctrl_q[13];
    wire disPowerUp = ctrl_q[14];
    wire [2:0] blockReact = ctrl_q[17:15];
    wire [1:0] relReactRaw = ctrl_q[19:18];
    // off delay hidden for staircase without manual off
    wire offDlyEn = ctrl_q[3] & (~stairEn | manualOff); // RULE_01
    // staircase limits release to follow or open
    wire [1:0] relReact = (stairEn && relReactRaw != `RCD_REL_OPEN) ?
        `RCD_REL_FOLLOW : relReactRaw; // RULE_17
    // durations in ticks
    wire [23:0] offLoad = toTicks(time0_q[9:8], time0_q[7:0]); // RULE_04
    wire [23:0] stairLoad = toTicks(time0_q[25:24], time0_q[23:16]); // RULE_05
    wire [23:0] pwStart = toTicks(2'h1, time1_q[7:0]); // RULE_06
    wire [4:0] pwIntF = (time1_q[12:8] > `RCD_PW_INT_MAX) ? `RCD_PW_INT_MAX : time1_q[12:8];
    wire [23:0] pwIntLoad = toTicks(2'h0, {3'h0, pwIntF});
    wire [23:0] pwGapLoad = toTicks(2'h1, time1_q[23:16]);
    // flashing factor clamped at its minimum
    wire [7:0] flashF = (flash_q[7:0] < `RCD_FLASH_MIN) ? `RCD_FLASH_MIN : flash_q[7:0];
    wire [23:0] flashLoad = toTicks(flash_q[9:8], flashF); // RULE_18

    // channel state
    logic lowOut_q, lowOut_d; // switching result before overrides
    logic storedSw_q, storedSw_d; // last switch telegram value
    logic [23:0] offCnt_q, offCnt_d; // off delay remaining
    logic [23:0] stairCnt_q, stairCnt_d; // staircase remaining
    logic [23:0] pwCnt_q, pwCnt_d; // prewarning phase remaining
    logic [1:0] pwLeft_q, pwLeft_d; // interruptions still due
    rcd_pw_state_t pwState_q, pwState_d;
    logic logicObj_q, prioObj_q, disObj_q; // higher function objects
    logic initDone_q; // power-up value taken
    logic disPrev_q; // disable state last cycle
    logic holdRel_q, holdRel_d; // relay held after release
    logic [23:0] flashCnt_q, flashCnt_d; // flashing half period
    logic relay_q, relay_d;

    wire offRun = |offCnt_q;
    wire stairRun = |stairCnt_q;
    wire offExpire = tick & (offCnt_q == 24'h000001);
    wire stairExpire = tick & (stairCnt_q == 24'h000001);
    wire swOn = swTel.strobe & swTel.value;
    wire swOff = swTel.strobe & ~swTel.value;
    wire stairStart = stairEn & swOn & (~stairRun | stairRetrig); // RULE_05
    wire manualCancel = stairEn & swOff & manualOff; // RULE_03
    wire offStartReq = swOff & offDlyEn & (stairEn ? (manualOff & (stairRun | lowOut_q)) : lowOut_q);
    wire offStart = offStartReq & (~offRun | offRetrig); // RULE_04
    wire pwHit = stairRun & tick & pwEn & (stairCnt_q == pwStart) & (pwState_q == PW_IDLE);

    // switching and staircase path; runs even while overridden
    always_comb begin
        lowOut_d = lowOut_q;
        storedSw_d = swTel.strobe ? swTel.value : storedSw_q; // RULE_16
        offCnt_d = (tick && offRun) ? offCnt_q - 24'h000001 : offCnt_q; // RULE_20
        stairCnt_d = (tick && stairRun) ? stairCnt_q - 24'h000001 : stairCnt_q;
        if (!stairEn) begin
            // plain switching only, staircase idle
            stairCnt_d = 24'h000000; // RULE_19
            if (swOn) begin
                lowOut_d = 1'b1;
                offCnt_d = 24'h000000;
            end else if (swOff && !offDlyEn) begin
                lowOut_d = 1'b0;
            end
        end else begin
            if (stairStart) begin
                stairCnt_d = stairLoad;
            end
            if (swOn) begin
                lowOut_d = 1'b1;
                offCnt_d = 24'h000000;
            end
            if (manualCancel) begin
                stairCnt_d = 24'h000000; // RULE_03
                if (!offDlyEn) begin
                    lowOut_d = 1'b0;
                end
            end
            if (stairExpire && !offRun) begin
                lowOut_d = 1'b0;
            end
        end
        if (offStart) begin
            offCnt_d = offLoad; // RULE_02
        end else if (offExpire) begin
            lowOut_d = 1'b0;
        end
    end

    // prewarning sequencer
    always_comb begin
        pwState_d = pwState_q;
        pwCnt_d = (tick && |pwCnt_q) ? pwCnt_q - 24'h000001 : pwCnt_q;
        pwLeft_d = pwLeft_q;
        case (pwState_q)
            PW_IDLE: begin
                if (pwHit && pwLeft_q != 2'h0) begin
                    pwState_d = PW_OFF; // RULE_06
                    pwCnt_d = pwIntLoad;
                    pwLeft_d = pwLeft_q - 2'h1;
                end
            end
            PW_OFF: begin
                if (tick && pwCnt_q <= 24'h000001) begin
                    pwState_d = (pwLeft_q != 2'h0) ? PW_GAP : PW_IDLE;
                    pwCnt_d = pwGapLoad;
                end
            end
            PW_GAP: begin
                if (tick && pwCnt_q <= 24'h000001) begin
                    pwState_d = PW_OFF;
                    pwCnt_d = pwIntLoad;
                    pwLeft_d = pwLeft_q - 2'h1;
                end
            end
            default: begin
                pwState_d = PW_IDLE;
            end
        endcase
        // cancel on manual off, end of staircase or a fresh start
        if (manualCancel || stairStart || !stairRun || !pwEn) begin
            pwState_d = PW_IDLE; // RULE_03
            pwCnt_d = 24'h000000;
            pwLeft_d = stairStart ? pwNum : 2'h0;
        end
    end

    // interruption only while a prewarning pulse runs
    wire lowRelay = lowOut_q & (pwState_q != PW_OFF);
    // logic or priority result, applied without delay
    wire useLogic = (hpSel == `RCD_HP_LOGIC); // RULE_09
    wire usePrio = (hpSel == `RCD_HP_PRIO);
    wire logicRes = logicOr ? (lowRelay | logicObj_q) : (lowRelay & logicObj_q);
    wire hpOut = useLogic ? logicRes :
        ((usePrio && prioObj_q) ? prioVal : lowRelay); // RULE_07 RULE_08
    // disable engages on the configured value
    wire disAct = disEn & initDone_q & (disObj_q == disPol); // RULE_13
    wire disEnter = disAct & ~disPrev_q;
    wire disLeave = ~disAct & disPrev_q;
    wire flashing = disAct & (blockReact == `RCD_BLK_FLASH);
    wire flashWrap = flashing & tick & (flashCnt_q <= 24'h000001);

    // relay selection with disable at the top
    always_comb begin
        relay_d = relay_q;
        holdRel_d = holdRel_q;
        flashCnt_d = (flashing && tick) ? flashCnt_q - 24'h000001 : flashCnt_q;
        if (disAct) begin
            // switch and logic results not turned into relay actions
            holdRel_d = 1'b0; // RULE_12 RULE_10
            if (disEnter) begin
                flashCnt_d = flashLoad;
                case (blockReact)
                    `RCD_BLK_TOGGLE: relay_d = ~relay_q; // RULE_15
                    `RCD_BLK_CLOSE: relay_d = 1'b1;
                    `RCD_BLK_OPEN: relay_d = 1'b0;
                    `RCD_BLK_FLASH: relay_d = ~relay_q;
                    default: relay_d = relay_q;
                endcase
            end else if (flashWrap) begin
                relay_d = ~relay_q; // RULE_18
                flashCnt_d = flashLoad;
            end
        end else if (disLeave) begin
            case (relReact)
                `RCD_REL_FOLLOW: relay_d = hpOut; // RULE_16
                `RCD_REL_CLOSE: relay_d = 1'b1;
                `RCD_REL_OPEN: relay_d = 1'b0;
                default: relay_d = relay_q;
            endcase
            holdRel_d = (relReact != `RCD_REL_FOLLOW);
        end else if (holdRel_q) begin
            // held until a new telegram asks for a change
            if (swTel.strobe || logicTel.strobe || prioTel.strobe) begin
                holdRel_d = 1'b0;
            end
        end else begin
            relay_d = hpOut; // RULE_08
        end
    end

    // state flops, all on the synchronised reset
    always_ff @(posedge clk_sys or negedge rstSync_q) begin
        if (!rstSync_q) begin
            lowOut_q <= 1'b0;
            storedSw_q <= 1'b0;
            offCnt_q <= 24'h000000;
            stairCnt_q <= 24'h000000;
            pwCnt_q <= 24'h000000;
            pwLeft_q <= 2'h0;
            pwState_q <= PW_IDLE;
            holdRel_q <= 1'b0;
            flashCnt_q <= 24'h000000;
            relay_q <= 1'b0;
            disPrev_q <= 1'b0;
        end else begin
            lowOut_q <= lowOut_d;
            storedSw_q <= storedSw_d;
            offCnt_q <= offCnt_d;
            stairCnt_q <= stairCnt_d;
            pwCnt_q <= pwCnt_d;
            pwLeft_q <= pwLeft_d;
            pwState_q <= pwState_d;
            holdRel_q <= holdRel_d;
            flashCnt_q <= flashCnt_d;
            relay_q <= relay_d;
            disPrev_q <= disAct;
        end
    end

    // higher function objects, one input each
    always_ff @(posedge clk_sys or negedge rstSync_q) begin
        if (!rstSync_q) begin
            logicObj_q <= 1'b0;
            prioObj_q <= 1'b0;
            disObj_q <= 1'b0;
            initDone_q <= 1'b0;
        end else begin
            initDone_q <= 1'b1;
            if (logicTel.strobe) logicObj_q <= logicTel.value; // RULE_11
            if (prioTel.strobe) prioObj_q <= prioTel.value;
            // power-up value on the first edge after release
            if (!initDone_q) disObj_q <= disPowerUp; // RULE_14
            else if (disTel.strobe) disObj_q <= disTel.value;
        end
    end

    // apb slave: one wait-free access cycle
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    wire setup = apbReq.psel & ~apbReq.penable;
    wire access = apbReq.psel & apbReq.penable & pready_q;
    wire wrEn = access & apbReq.pwrite;
    wire hitCtrl = apbReq.paddr == `RCD_OFF_CTRL;
    wire hitTime0 = apbReq.paddr == `RCD_OFF_TIME0;
    wire hitTime1 = apbReq.paddr == `RCD_OFF_TIME1;
    wire hitFlash = apbReq.paddr == `RCD_OFF_FLASH;
    wire hitStatus = apbReq.paddr == `RCD_OFF_STATUS;
    wire hitAny = hitCtrl | hitTime0 | hitTime1 | hitFlash | hitStatus;
    // status shows the channel's own state
    wire [31:0] statusWord = {26'h0000000, (pwState_q != PW_IDLE), offRun, stairRun,
        disAct, storedSw_q, relay_q};
    wire [31:0] rdMux = hitCtrl ? ctrl_q : hitTime0 ? time0_q : hitTime1 ? time1_q :
        hitFlash ? flash_q : hitStatus ? statusWord : 32'h00000000;

    // answer prepared at setup, pready raised for the access cycle
    always_ff @(posedge clk_sys or negedge rstSync_q) begin
        if (!rstSync_q) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~hitAny; // unmapped address flags an error
            prdata_q <= (setup && !apbReq.pwrite) ? rdMux : 32'h00000000;
        end
    end

    // configuration writes; status is read-only
    always_ff @(posedge clk_sys or negedge rstSync_q) begin
        if (!rstSync_q) begin
            ctrl_q <= `RCD_RST_CTRL;
            time0_q <= `RCD_RST_TIME0;
            time1_q <= `RCD_RST_TIME1;
            flash_q <= `RCD_RST_FLASH;
        end else if (wrEn) begin
            if (hitCtrl) ctrl_q <= {12'h000, apbReq.pwdata[19:0]};
            if (hitTime0) time0_q <= {6'h00, apbReq.pwdata[25:16], 6'h00, apbReq.pwdata[9:0]};
            if (hitTime1) time1_q <= {8'h00, apbReq.pwdata[23:16], 3'h0, apbReq.pwdata[12:0]};
            if (hitFlash) flash_q <= {22'h000000, apbReq.pwdata[9:0]};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign relayDrive = relay_q;
endmodule
`default_nettype wire

// File: rcd_channel_properties.sv
// port assertions for the relay channel
`timescale 1ns/1ps
`default_nettype none
module rcd_channel_checker import rcd_pkg::*; #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire rcd_apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire rcd_tel_t swTel,
    input wire rcd_tel_t logicTel,
    input wire rcd_tel_t prioTel,
    input wire rcd_tel_t disTel,
    input wire logic relayDrive
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [31:0] ctrl_q; // shadow of the control word
    logic disVal_q; // last disable value
    logic disSeen_q; // disable telegram since last control write
    logic prioVal_q; // last priority value
    // a write lands only in the access cycle
    wire ctrlWr = apbReq.psel & apbReq.penable & pready & apbReq.pwrite & (apbReq.paddr == 8'h00);
    wire mapped = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr <= 8'h10);
    // a config write may engage disable by itself, so trust only telegrams
    wire disOn = ctrl_q[12] & disSeen_q & (disVal_q == ctrl_q[13]);
    wire [2:0] blk = ctrl_q[17:15];
    wire plainMode = !(ctrl_q[0] | ctrl_q[3] | ctrl_q[12] | (^ctrl_q[9:8]));
    // follow config and override objects
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 32'h0;
            disVal_q <= 1'b0;
            disSeen_q <= 1'b0;
            prioVal_q <= 1'b0;
        end else begin
            if (ctrlWr) ctrl_q <= apbReq.pwdata;
            if (disTel.strobe) disVal_q <= disTel.value;
            if (prioTel.strobe) prioVal_q <= prioTel.value;
            disSeen_q <= !ctrlWr & (disSeen_q | disTel.strobe);
        end
    end
    sequence s_setup;
        apbReq.psel && !apbReq.penable;
    endsequence
    property p_ready_next;
        s_setup |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no pready after setup");
    property p_ready_access;
        pready |-> apbReq.penable && $past(apbReq.psel) && !$past(apbReq.penable);
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("pready outside access");
    property p_err_map;
        (s_setup ##0 !mapped) |=> pslverr && pready;
    endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped address not refused");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
    property p_plain;
        plainMode && swTel.strobe |=> ##1 relayDrive == $past(swTel.value, 2);
    endproperty
    a_plain: assert property (p_plain) else $error("plain switch not followed");
    property p_logic_and;
        ctrl_q[9:8] == 2'h1 && !ctrl_q[10] && !disOn && logicTel.strobe && !logicTel.value |=> ##1 !relayDrive;
    endproperty
    a_logic_and: assert property (p_logic_and) else $error("logic zero not immediate");
    property p_prio_hold;
        ctrl_q[9:8] == 2'h2 && !ctrl_q[12] && prioVal_q && $past(prioVal_q) |-> relayDrive == ctrl_q[11];
    endproperty
    a_prio_hold: assert property (p_prio_hold) else $error("priority value not held");
    property p_dis_fixed;
        disOn && $past(disOn) && (blk == 3'h2 || blk == 3'h3) |-> relayDrive == (blk == 3'h2);
    endproperty
    a_dis_fixed: assert property (p_dis_fixed) else $error("blocking position lost");
    property p_dis_ignore;
        disOn && $past(disOn) && blk != 3'h4 && !disTel.strobe && !ctrlWr |=> $stable(relayDrive);
    endproperty
    a_dis_ignore: assert property (p_dis_ignore) else $error("relay moved while disabled");
endmodule
bind rcd_channel rcd_channel_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_sys, .rst_n, .apbReq, .prdata,
    .pready, .pslverr, .swTel, .logicTel, .prioTel, .disTel, .relayDrive);
`default_nettype wire

// File: rcd_bus_sender.sv
// telegram source standing in for the other bus devices
`timescale 1ns/1ps
`default_nettype none
module rcd_bus_sender import rcd_pkg::*; (
    input wire logic clk_sys,
    output var rcd_tel_t swTel,
    output var rcd_tel_t logicTel,
    output var rcd_tel_t prioTel,
    output var rcd_tel_t disTel
);
    rcd_tel_t tel_q [4]; // 0 switch, 1 logic, 2 priority, 3 disable
    assign swTel = tel_q[0];
    assign logicTel = tel_q[1];
    assign prioTel = tel_q[2];
    assign disTel = tel_q[3];
    // objects start quiet
    initial begin
        tel_q = '{default: '0};
    end
    // one-cycle strobe, then the value inverts so none relies on it
    task automatic send(input int unsigned k, input logic v);
        @(posedge clk_sys);
        tel_q[k] <= '{1'b1, v};
        @(posedge clk_sys);
        tel_q[k] <= '{1'b0, ~v};
    endtask
endmodule
`default_nettype wire

// File: relay_channel_delay_disable_control_tb.sv
// self-checking bench for the relay channel
`timescale 1ns/1ps
`default_nettype none
module relay_channel_delay_disable_control_tb import rcd_pkg::*;;
    logic clk_sys;
    logic rst_n;
    rcd_apb_req_t apbReq;
    logic [31:0] prdata;
    logic pready, pslverr;
    rcd_tel_t swTel, logicTel, prioTel, disTel;
    logic relayDrive;
    int errorCnt, comparisons;
    logic [31:0] rdv;
    logic rerr;
    int n, k, falls, rises;
    // ten cycles per tick
    rcd_channel #(.TICK_CYCLES(10)) dut_u (.clk_sys, .rst_n, .apbReq, .prdata, .pready, .pslverr, .swTel,
        .logicTel, .prioTel, .disTel, .relayDrive);
    rcd_bus_sender bus_u (.clk_sys, .swTel, .logicTel, .prioTel, .disTel);
    // 200 MHz
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        if (errorCnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rstDut();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    // setup, access until pready, one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w = 0;
        apbReq <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            w++;
        end while (pready !== 1'b1 && w < 16);
        rdv = prdata;
        rerr = pslverr;
        apbReq <= '0;
        @(posedge clk_sys);
        check(w < 16, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eErr = 1'b0);
        apb(1'b0, a, 32'h0);
        check(rdv, exp);
        check(rerr, eErr);
    endtask
    // relay lags the strobe edge by one
    task automatic relay(input logic v);
        @(posedge clk_sys);
        #1;
        check(relayDrive, v);
        @(posedge clk_sys);
    endtask
    task automatic waitRel(input logic v, input int maxc);
        n = 0;
        while (relayDrive !== v && n < maxc) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        @(posedge clk_sys);
    endtask
    initial begin
        rst_n = 1'b0;
        apbReq = '0;
        errorCnt = 0;
        comparisons = 0;
        rstDut();
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h01550178);
        rd(8'h08, 32'h0005051E);
        rd(8'h0C, 32'h0000010A);
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h0);
        rd(8'h20, 32'h0, 1'b1);
        rd(8'h06, 32'h0, 1'b1);
        bus_u.send(0, 1'b1);
        relay(1'b1);
        bus_u.send(0, 1'b0);
        relay(1'b0);
        // off delay of five ticks in plain mode
        apb(1'b1, 8'h00, 32'h8);
        apb(1'b1, 8'h04, 32'h01550005);
        bus_u.send(0, 1'b1);
        bus_u.send(0, 1'b0);
        repeat (28) @(posedge clk_sys);
        relay(1'b1);
        waitRel(1'b0, 60);
        check(n < 40, 1'b1);
        // staircase without manual off ignores the off command
        rstDut();
        apb(1'b1, 8'h00, 32'h9);
        apb(1'b1, 8'h04, 32'h00040005);
        bus_u.send(0, 1'b1);
        bus_u.send(0, 1'b0);
        relay(1'b1);
        waitRel(1'b0, 80);
        check(n > 15 && n < 60, 1'b1);
        // manual off: off delay outlives cancelled staircase
        rstDut();
        apb(1'b1, 8'h00, 32'hAD);
        apb(1'b1, 8'h04, 32'h01020103);
        apb(1'b1, 8'h08, 32'h00010201);
        bus_u.send(0, 1'b1);
        bus_u.send(0, 1'b0);
        falls = 0;
        repeat (250) begin
            @(posedge clk_sys);
            if (relayDrive !== 1'b1) falls++;
        end
        check(falls, 0);
        waitRel(1'b0, 100);
        check(n < 90, 1'b1);
        // two warnings before a 6 s staircase ends
        rstDut();
        apb(1'b1, 8'h00, 32'hA1);
        apb(1'b1, 8'h04, 32'h01060000);
        apb(1'b1, 8'h08, 32'h00010203);
        bus_u.send(0, 1'b1);
        falls = 0;
        rises = 0;
        k = 0;
        repeat (800) begin
            @(posedge clk_sys);
            if (relayDrive !== k[0]) begin
                falls += k;
                rises += 1 - k;
                k = 1 - k;
            end
        end
        check(falls, 3);
        check(rises, 3);
        // priority forces closed and holds against switching
        rstDut();
        apb(1'b1, 8'h00, 32'hA00);
        bus_u.send(2, 1'b1);
        relay(1'b1);
        bus_u.send(0, 1'b0);
        relay(1'b1);
        // logic and, then logic or
        rstDut();
        apb(1'b1, 8'h00, 32'h100);
        bus_u.send(0, 1'b1);
        bus_u.send(1, 1'b0);
        relay(1'b0);
        bus_u.send(1, 1'b1);
        relay(1'b1);
        rstDut();
        apb(1'b1, 8'h00, 32'h500);
        bus_u.send(1, 1'b1);
        relay(1'b1);
        // blocking reactions other than flashing, each with a release reaction
        for (k = 0; k < 4; k++) begin
            rstDut();
            apb(1'b1, 8'h00, 32'(32'h3000 | (k << 15) | (((k + 1) % 4) << 18)));
            bus_u.send(0, 1'b1);
            relay(1'b1);
            bus_u.send(3, 1'b1);
            relay(~k[0]);
            bus_u.send(0, 1'b1);
            bus_u.send(0, 1'b0);
            relay(~k[0]);
            bus_u.send(3, 1'b0);
            relay(k == 1);
        end
        // disable on zero, over a forcing priority
        rstDut();
        apb(1'b1, 8'h00, 32'h99A00);
        bus_u.send(3, 1'b1);
        bus_u.send(0, 1'b1);
        relay(1'b1);
        bus_u.send(3, 1'b0);
        relay(1'b0);
        bus_u.send(2, 1'b1);
        relay(1'b0);
        bus_u.send(3, 1'b1);
        relay(1'b1);
        // flash factor below five is clamped to five, giving a 50-cycle half period
        rstDut();
        apb(1'b1, 8'h00, 32'h23000);
        apb(1'b1, 8'h0C, 32'h2);
        bus_u.send(3, 1'b1);
        relay(1'b1);
        waitRel(1'b0, 100);
        waitRel(1'b1, 100);
        check(n >= 38 && n <= 62, 1'b1);
        tally_and_finish();
    end
    // hang guard; tests need a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        errorCnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
